// ===== include/eccs_pkg.sv
/*
  Shared constants and carrier types for the flash command sequencer
  and array access arbiter. Assumes a 50 MHz system clock.
*/
package eccs_pkg;
  // Register byte offsets
  localparam logic [4:0] A_CMD = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_PROT = 5'h08;
  localparam logic [4:0] A_KEY = 5'h0c;
  localparam logic [4:0] A_MARG = 5'h10;
  // Command register fields
  localparam int C_EE = 8;
  localparam int C_HB = 9;
  localparam int C_CNT = 10;
  localparam int C_ADDR = 16;
  // Status register fields
  localparam int S_COMMAND_COMPLETE_FLAG = 7;
  localparam int S_ACCESS_ERROR_FLAG = 5;
  localparam int S_ILL = 2;
  localparam int S_FAIL = 1;
  // Protection register fields
  localparam int P_LO = 0;
  localparam int P_HI = 1;
  localparam int P_PF = 2;
  localparam int P_EE = 3;
  // Timing of the pre-array window
  localparam int CLK_NS = 20;
  localparam int SETUP_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Override key, value arbitrary
  localparam logic [31:0] OVR_KEY = 32'h5a5a_c3c3;
  // Command codes
  localparam logic [7:0] K_EVALL = 8'h01;
  localparam logic [7:0] K_EVBLK = 8'h02;
  localparam logic [7:0] K_EVPF = 8'h03;
  localparam logic [7:0] K_RDONCE = 8'h04;
  localparam logic [7:0] K_PGPF = 8'h06;
  localparam logic [7:0] K_PGONCE = 8'h07;
  localparam logic [7:0] K_ERALL = 8'h08;
  localparam logic [7:0] K_ERBLK = 8'h09;
  localparam logic [7:0] K_ERPF = 8'h0a;
  localparam logic [7:0] K_UNSEC = 8'h0b;
  localparam logic [7:0] K_BDKEY = 8'h0c;
  localparam logic [7:0] K_UMARG = 8'h0d;
  localparam logic [7:0] K_FMARG = 8'h0e;
  localparam logic [7:0] K_EVEE = 8'h10;
  localparam logic [7:0] K_PGEE = 8'h11;
  localparam logic [7:0] K_EREE = 8'h12;
  localparam logic [7:0] K_OVR = 8'h13;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_SETUP = 3'h2, ST_ARRAY = 3'h4
  } eccs_state_t;
  // Array activity class used by the collision check
  typedef enum logic [2:0] {
    CL_NONE = 3'h0, CL_READ = 3'h1, CL_PROG = 3'h2,
    CL_SECT = 3'h3, CL_MASS = 3'h4
  } eccs_cls_t;

  typedef struct packed {
    logic awvalid; logic [31:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [31:0] araddr;
    logic rready;
  } eccs_axi_req_t;
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid; logic [1:0] bresp;
    logic arready;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } eccs_axi_rsp_t;
  typedef struct packed {
    logic pf_req; logic ee_req; logic hb;
  } eccs_rd_req_t;
  typedef struct packed {
    logic pf_gnt; logic ee_gnt; logic margin; logic illegal;
  } eccs_rd_rsp_t;
  typedef struct packed {
    logic start; logic verify; logic ee; logic hb;
    logic [7:0] code; logic [2:0] cnt; logic [15:0] addr;
  } eccs_arr_t;
  typedef struct packed {
    eccs_state_t st; logic [7:0] tmr; logic ph;
    logic [31:0] cmd; logic [3:0] prot; logic [1:0] ovr;
    logic [31:0] key; logic [1:0] mlev; logic mfld;
    logic command_complete_flag; logic access_error_flag; logic ill_seen; logic fail;
    logic [1:0] mode_s;
    logic aw_have; logic [4:0] aw_a;
    logic w_have; logic [31:0] wd; logic [3:0] ws;
    eccs_axi_rsp_t ax; logic rr;
    eccs_rd_rsp_t rd; eccs_arr_t arr;
  } eccs_st_t;
endpackage : eccs_pkg

// ===== design/eccs_top.sv
/*
  Command sequencer and read arbiter for a combined program flash and
  EEPROM controller, with an AXI4-Lite register slave.
  Assumes the read requesters and array engine share i_clk; the mode
  strap is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module eccs_top
  import eccs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register bus
  input wire eccs_axi_req_t i_axi,
  output eccs_axi_rsp_t o_axi,
  // Mode strap
  input wire logic i_special_mode,
  // CPU array reads
  input wire eccs_rd_req_t i_rd,
  output eccs_rd_rsp_t o_rd,
  // Array engine
  output eccs_arr_t o_arr,
  input wire logic i_arr_done,
  input wire logic i_arr_fail
);
  logic [1:0] rst_q;
  logic rst_n;
  eccs_st_t s_r, s_nxt;
  logic [7:0] code;
  logic wr_go, launch_req, launch_ok, launch_bad, cmd_ok;
  logic pf_open, ee_open, same_hb, margin, pick_pf, pick_ee;
  logic ill_pf, ill_ee;
  logic [2:0] cnt;
  eccs_cls_t pf_raw, ee_raw, pf_cls, ee_cls;
  logic [31:0] rdv;
  logic [31:0] wm;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Launch decode, evaluated on the write that hits the status register
  assign code = s_r.cmd[7:0];
  assign cnt = s_r.cmd[C_CNT +: 3];
  assign pf_open = (s_r.prot[P_LO] && s_r.prot[P_HI] && s_r.prot[P_PF])
                   || s_r.ovr[0];
  assign ee_open = s_r.prot[P_EE] || s_r.ovr[1];
  assign wr_go = s_r.aw_have && s_r.w_have && !s_r.ax.bvalid;
  assign launch_req = wr_go && (s_r.aw_a == A_STAT) && s_r.wd[S_COMMAND_COMPLETE_FLAG]
                      && s_r.ws[0] && s_r.command_complete_flag && !s_r.access_error_flag;

  // Command legality
  always_comb begin
    case (code)
      K_EVALL, K_EVBLK, K_EVPF, K_RDONCE, K_PGPF, K_PGONCE,
      K_ERPF, K_UNSEC, K_BDKEY, K_UMARG, K_EVEE, K_EREE: begin
        cmd_ok = 1'b1;
      end
      K_ERALL: begin
        cmd_ok = pf_open && ee_open;
      end
      K_ERBLK: begin
        cmd_ok = s_r.cmd[C_EE] ? ee_open : pf_open;
      end
      K_FMARG: begin
        cmd_ok = s_r.mode_s[1];
      end
      K_PGEE: begin
        cmd_ok = (cnt != 3'h0) && (cnt <= 3'h4);
      end
      K_OVR: begin
        cmd_ok = (s_r.key == OVR_KEY);
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
  end
  assign launch_ok = launch_req && cmd_ok;
  assign launch_bad = launch_req && !cmd_ok;

  // Array activity of the running command, per array
  always_comb begin
    pf_raw = CL_NONE;
    ee_raw = CL_NONE;
    case (code)
      K_EVALL: begin
        pf_raw = CL_READ;
        ee_raw = CL_READ;
      end
      K_EVBLK: begin
        if (s_r.cmd[C_EE]) begin
          ee_raw = CL_READ;
        end else begin
          pf_raw = CL_READ;
        end
      end
      K_EVPF, K_RDONCE: begin
        pf_raw = CL_READ;
      end
      K_PGPF, K_PGONCE: begin
        pf_raw = CL_PROG;
      end
      K_ERPF: begin
        pf_raw = CL_SECT;
      end
      K_ERALL: begin
        pf_raw = CL_MASS;
        ee_raw = CL_MASS;
      end
      K_ERBLK: begin
        if (s_r.cmd[C_EE]) begin
          ee_raw = CL_MASS;
        end else begin
          pf_raw = CL_MASS;
        end
      end
      K_UNSEC: begin
        pf_raw = s_r.ph ? CL_READ : CL_MASS;
        ee_raw = s_r.ph ? CL_READ : CL_MASS;
      end
      K_EVEE: begin
        ee_raw = CL_READ;
      end
      K_PGEE: begin
        ee_raw = CL_PROG;
      end
      K_EREE: begin
        ee_raw = CL_SECT;
      end
      default: begin
        pf_raw = CL_NONE;
      end
    endcase
    // Arrays count as busy only once the array phase has begun
    pf_cls = (s_r.st == ST_ARRAY) ? pf_raw : CL_NONE;
    ee_cls = (s_r.st == ST_ARRAY) ? ee_raw : CL_NONE;
  end

  // Read arbitration and collision check
  assign margin = (s_r.mlev != 2'h0);
  assign same_hb = (i_rd.hb == s_r.cmd[C_HB]);
  // A source just granted is skipped so its held request is not doubled
  assign pick_pf = i_rd.pf_req && !s_r.rd.pf_gnt
                   && (!i_rd.ee_req || s_r.rd.ee_gnt || !s_r.rr);
  assign pick_ee = i_rd.ee_req && !s_r.rd.ee_gnt && !pick_pf;
  assign ill_pf = same_hb && ((pf_cls != CL_NONE) || ((ee_cls != CL_NONE)
                  && (margin || ee_cls == CL_MASS)));
  assign ill_ee = same_hb && ((ee_cls != CL_NONE)
                  || (pf_cls != CL_NONE));

  // Register read mux
  always_comb begin
    rdv = 32'h0;
    case (i_axi.araddr[4:0])
      A_CMD: rdv = s_r.cmd;
      A_STAT: begin
        rdv[S_COMMAND_COMPLETE_FLAG] = s_r.command_complete_flag;
        rdv[S_ACCESS_ERROR_FLAG] = s_r.access_error_flag;
        rdv[S_ILL] = s_r.ill_seen;
        rdv[S_FAIL] = s_r.fail;
      end
      A_PROT: rdv = {26'h0, s_r.ovr, s_r.prot};
      A_MARG: rdv = {29'h0, s_r.mfld, s_r.mlev};
      default: rdv = 32'h0; // Key reads back as zero
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    wm = 32'h0;
    s_nxt.mode_s = {s_r.mode_s[0], i_special_mode};
    s_nxt.arr.start = 1'b0;
    s_nxt.rd = '0;
    // Write address and data captured independently
    if (i_axi.awvalid && s_r.ax.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_a = i_axi.awaddr[4:0];
    end
    if (i_axi.wvalid && s_r.ax.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wd = i_axi.wdata;
      s_nxt.ws = i_axi.wstrb;
    end
    if (s_r.ax.bvalid && i_axi.bready) begin
      s_nxt.ax.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.ax.bvalid = 1'b1;
      s_nxt.ax.bresp = RESP_OK;
      case (s_r.aw_a)
        A_CMD: begin
          // Parameters are frozen while a command runs
          if (s_r.command_complete_flag) begin
            s_nxt.cmd = merge(s_r.cmd, s_r.wd, s_r.ws);
          end
        end
        A_STAT: begin
          if (s_r.ws[0] && s_r.wd[S_ACCESS_ERROR_FLAG]) begin
            s_nxt.access_error_flag = 1'b0;
          end
          if (s_r.ws[0] && s_r.wd[S_ILL]) begin
            s_nxt.ill_seen = 1'b0;
          end
        end
        A_PROT: begin
          if (s_r.command_complete_flag) begin
            wm = merge({28'h0, s_r.prot}, s_r.wd, s_r.ws);
            s_nxt.prot = wm[3:0];
          end
        end
        A_KEY: begin
          s_nxt.key = merge(s_r.key, s_r.wd, s_r.ws);
        end
        A_MARG: begin
          s_nxt.ax.bresp = RESP_OK;
        end
        default: begin
          s_nxt.ax.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.ax.awready = !s_nxt.aw_have && !s_nxt.ax.bvalid;
    s_nxt.ax.wready = !s_nxt.w_have && !s_nxt.ax.bvalid;
    // Read channel, one outstanding read
    if (s_r.ax.rvalid && i_axi.rready) begin
      s_nxt.ax.rvalid = 1'b0;
    end
    if (i_axi.arvalid && s_r.ax.arready) begin
      s_nxt.ax.rvalid = 1'b1;
      s_nxt.ax.rdata = rdv;
      s_nxt.ax.rresp = (i_axi.araddr[4:0] <= A_MARG
                        && i_axi.araddr[1:0] == 2'h0)
                       ? RESP_OK : RESP_SLVERR;
    end
    s_nxt.ax.arready = !s_nxt.ax.rvalid;
    // Launch; error set wins over the clear in the same write
    if (launch_bad) begin
      s_nxt.access_error_flag = 1'b1;
    end
    if (launch_ok) begin
      s_nxt.command_complete_flag = 1'b0;
      s_nxt.fail = 1'b0;
      s_nxt.ph = 1'b0;
      s_nxt.tmr = 8'(SETUP_CYC - 1);
      s_nxt.st = ST_SETUP;
    end
    // Sequencer
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.tmr = launch_ok ? s_nxt.tmr : 8'h0;
      end
      ST_SETUP: begin
        if (s_r.tmr != 8'h0) begin
          s_nxt.tmr = s_r.tmr - 8'h1;
        end else if (pf_raw != CL_NONE || ee_raw != CL_NONE) begin
          s_nxt.st = ST_ARRAY;
          s_nxt.arr.start = 1'b1;
          s_nxt.arr.verify = 1'b0;
          s_nxt.arr.code = code;
          s_nxt.arr.ee = s_r.cmd[C_EE];
          s_nxt.arr.hb = s_r.cmd[C_HB];
          s_nxt.arr.cnt = cnt;
          s_nxt.arr.addr = s_r.cmd[C_ADDR +: 16];
        end else begin
          // Register-only commands finish without touching an array
          if (code == K_UMARG) begin
            s_nxt.mlev = s_r.cmd[C_ADDR +: 2];
            s_nxt.mfld = 1'b0;
          end
          if (code == K_FMARG) begin
            s_nxt.mlev = s_r.cmd[C_ADDR +: 2];
            s_nxt.mfld = 1'b1;
          end
          if (code == K_OVR) begin
            s_nxt.ovr = s_r.cmd[C_ADDR +: 2];
          end
          s_nxt.command_complete_flag = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_ARRAY: begin
        if (i_arr_done) begin
          s_nxt.fail = s_r.fail || i_arr_fail;
          if (code == K_UNSEC && !s_r.ph) begin
            s_nxt.ph = 1'b1;
            s_nxt.arr.start = 1'b1;
            s_nxt.arr.verify = 1'b1;
          end else begin
            s_nxt.command_complete_flag = 1'b1;
            s_nxt.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // Grant one read; flag only the colliding cycle
    if (pick_pf || pick_ee) begin
      s_nxt.rr = pick_pf;
      s_nxt.rd.pf_gnt = pick_pf;
      s_nxt.rd.ee_gnt = pick_ee;
      s_nxt.rd.margin = margin;
      s_nxt.rd.illegal = pick_pf ? ill_pf : ill_ee;
      if (s_nxt.rd.illegal) begin
        s_nxt.ill_seen = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.command_complete_flag <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_axi = s_r.ax;
  assign o_rd = s_r.rd; // Illegal pulse doubles as machine exception
  assign o_arr = s_r.arr;

  // Checks
  a_launch_clears: assert property (@(posedge i_clk) disable iff (!rst_n)
    launch_ok |=> !s_r.command_complete_flag && s_r.st == ST_SETUP)
    else $error("launch did not clear complete flag");
  a_bad_code: assert property (@(posedge i_clk) disable iff (!rst_n)
    launch_bad |=> s_r.access_error_flag && s_r.command_complete_flag && s_r.st == ST_IDLE)
    else $error("invalid command not refused");
  a_one_read: assert property (@(posedge i_clk) disable iff (!rst_n)
    !(o_rd.pf_gnt && o_rd.ee_gnt))
    else $error("two reads granted at once");
  a_ill_cycle: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_rd.illegal |-> (o_rd.pf_gnt || o_rd.ee_gnt)
      && $past(s_r.st) == ST_ARRAY)
    else $error("illegal access outside a colliding read");
  a_setup_window: assert property (@(posedge i_clk) disable iff (!rst_n)
    launch_ok |=> (s_r.st == ST_SETUP && !o_arr.start)[*8])
    else $error("array started before the read window");
  a_mass_blocks: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pick_pf && same_hb && ee_cls == CL_MASS) |=> o_rd.illegal)
    else $error("read during mass erase not flagged");
  a_pf_while_prog: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pick_pf && pf_cls == CL_NONE && ee_cls == CL_PROG && !margin)
      |=> o_rd.pf_gnt && !o_rd.illegal)
    else $error("allowed read flagged illegal");
  a_margin_read: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pick_pf && same_hb && ee_cls != CL_NONE && margin) |=> o_rd.illegal)
    else $error("margin read collision not flagged");
  a_erase_prot: assert property (@(posedge i_clk) disable iff (!rst_n)
    (launch_req && code == K_ERALL && !(pf_open && ee_open))
      |=> s_r.access_error_flag && s_r.st == ST_IDLE)
    else $error("erase all ran while protected");
  a_field_mode: assert property (@(posedge i_clk) disable iff (!rst_n)
    (launch_req && code == K_FMARG && !s_r.mode_s[1]) |=> s_r.access_error_flag)
    else $error("field margin accepted in normal mode");
  a_start_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_arr.start |-> s_r.st == ST_ARRAY ##1 !o_arr.start)
    else $error("array start not a single pulse");
endmodule : eccs_top
`default_nettype wire

// ===== sim/eccs_arr_model.sv
/*
  Behavioural array engine that answers the sequencer's start pulses.
  Assumes it shares i_clk and the raw reset with the design.
*/
`timescale 1ns/10ps
`default_nettype none
module eccs_arr_model
  import eccs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Array command from the sequencer
  input wire eccs_arr_t i_arr,
  // Behaviour chosen by the bench
  input wire logic [7:0] i_delay,
  input wire logic i_fail,
  // Completion back to the sequencer
  output logic o_done,
  output logic o_fail
);
  logic [7:0] cnt_r;
  logic busy_r;
  logic ver_r;
  // A start, or the move into the verify pass, begins one timed job
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      ver_r <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      ver_r <= i_arr.verify;
      o_done <= 1'b0;
      o_fail <= ~o_fail; // Unqualified outside done, so never steady
      if (i_arr.start || (i_arr.verify && !ver_r)) begin
        busy_r <= 1'b1;
        cnt_r <= i_delay;
      end else if (busy_r) begin
        if (cnt_r == 8'h00) begin
          busy_r <= 1'b0;
          o_done <= 1'b1;
          o_fail <= i_fail;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule : eccs_arr_model
`default_nettype wire

// ===== sim/tb_top.sv
/*
  Self-checking bench: commands, refusals, margins and read collisions.
  Assumes the array model answers each start after the delay set here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import eccs_pkg::*;
();
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic special = 1'b0;
  logic efail = 1'b0;
  logic [7:0] edly = 8'h05;
  eccs_axi_req_t axi = '0;
  eccs_axi_rsp_t o_axi;
  eccs_rd_req_t rd = '0;
  eccs_rd_rsp_t o_rd;
  eccs_arr_t o_arr;
  eccs_arr_t last_arr = '0;
  logic done;
  logic dfail;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_start = 0;
  int n_done = 0;
  int st_cyc = 0;

  eccs_top eccs_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(axi),
    .o_axi(o_axi), .i_special_mode(special), .i_rd(rd), .o_rd(o_rd),
    .o_arr(o_arr), .i_arr_done(done), .i_arr_fail(dfail));
  eccs_arr_model eccs_arr_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_arr(o_arr), .i_delay(edly), .i_fail(efail), .o_done(done),
    .o_fail(dfail));

  always #10 i_clk = ~i_clk;
  // Cycle count and a record of every array start and completion
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) n_done <= n_done + 1;
    if (o_arr.start === 1'b1) begin
      n_start <= n_start + 1;
      last_arr <= o_arr;
      st_cyc <= cyc;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] dat,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    axi.awvalid <= 1'b1;
    axi.awaddr <= {27'h0, a};
    axi.wvalid <= 1'b1;
    axi.wdata <= dat;
    axi.wstrb <= 4'hf;
    axi.bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_axi.awready === 1'b1) axi.awvalid <= 1'b0;
      if (o_axi.wready === 1'b1) axi.wvalid <= 1'b0;
    end while (o_axi.bvalid !== 1'b1 && n < 100);
    axi.bready <= 1'b0;
    r = o_axi.bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] dat,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    axi.arvalid <= 1'b1;
    axi.araddr <= {27'h0, a};
    axi.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_axi.arready === 1'b1) axi.arvalid <= 1'b0;
    end while (o_axi.rvalid !== 1'b1 && n < 100);
    axi.rready <= 1'b0;
    dat = o_axi.rdata;
    r = o_axi.rresp;
  endtask : axi_rd

  function automatic logic [31:0] mk(input logic [7:0] c, input logic ee,
      input logic [2:0] n, input logic [15:0] hi);
    return {hi, 3'h0, n, 1'b0, ee, c};
  endfunction : mk

  // Launch is a write of one to the complete flag
  task automatic launch(input logic [31:0] cmd);
    logic [1:0] r;
    axi_wr(A_CMD, cmd, r);
    axi_wr(A_STAT, 32'h80, r);
  endtask : launch

  task automatic finish(output logic [31:0] d);
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axi_rd(A_STAT, d, r);
      n++;
    end while (d[S_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 100);
  endtask : finish

  // One read request held until its grant, sampled mid-cycle
  task automatic rdq(input logic pf, input logic hb, output eccs_rd_rsp_t s);
    int n;
    n = 0;
    @(posedge i_clk);
    rd.pf_req <= pf;
    rd.ee_req <= ~pf;
    rd.hb <= hb;
    do begin
      @(negedge i_clk);
      n++;
    end while ((o_rd.pf_gnt | o_rd.ee_gnt) !== 1'b1 && n < 20);
    s = o_rd;
    @(posedge i_clk);
    rd.pf_req <= 1'b0;
    rd.ee_req <= 1'b0;
  endtask : rdq

  task automatic run(input logic [31:0] cmd, input logic err, input int nd,
                     output logic [31:0] d);
    logic [1:0] r;
    int s0;
    int d0;
    int dl;
    s0 = n_start;
    d0 = n_done;
    launch(cmd);
    dl = cyc;
    axi_rd(A_STAT, d, r);
    check("access_error_flag", d[S_ACCESS_ERROR_FLAG], err);
    check("command_complete_flag_run", d[S_COMMAND_COMPLETE_FLAG], err);
    // Give a wrongly accepted command time to show its start
    if (err) begin
      repeat (SETUP_CYC + 4) @(posedge i_clk);
      axi_wr(A_STAT, 32'h20, r);
    end
    finish(d);
    dl = st_cyc - dl;
    check("command_complete_flag_end", d[S_COMMAND_COMPLETE_FLAG], 1'b1);
    check("n_done", n_done - d0, nd);
    check("started", n_start != s0, nd != 0);
    if (nd == 1) check("setup", dl inside {[SETUP_CYC-4:SETUP_CYC]}, 1);
    if (nd != 0) check("code", last_arr.code, cmd[7:0]);
  endtask : run

  // Read during the setup window, then one read in the array phase
  task automatic conc(input logic [31:0] cmd, input logic pf, input logic hb,
                      input logic ill);
    eccs_rd_rsp_t s;
    logic [31:0] d;
    logic [1:0] r;
    int s0;
    int n;
    s0 = n_start;
    n = 0;
    edly <= 8'h28;
    launch(cmd);
    rdq(1'b0, hb, s);
    check("setup_rd", {s.ee_gnt, s.illegal}, 2'b10);
    while (n_start == s0 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    rdq(pf, hb, s);
    check("conc", {s.pf_gnt, s.ee_gnt, s.illegal}, {pf, ~pf, ill});
    @(negedge i_clk);
    check("ill_once", o_rd.illegal, 1'b0);
    finish(d);
    check("ill_seen", d[S_ILL], ill);
    axi_wr(A_STAT, 32'h04, r);
    edly <= 8'h05;
  endtask : conc

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(A_STAT, d, r);
    check("stat_rst", d, 32'h80);
    axi_rd(A_MARG, d, r);
    check("marg_rst", d, 32'h0);
    axi_rd(5'h14, d, r);
    check("unmap_resp", r, RESP_SLVERR);
    check("unmap_data", d, 32'h0);
    axi_wr(5'h14, 32'h0, r);
    check("unmap_wr", r, RESP_SLVERR);
  endtask : t_reset

  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0] r;
    int s0;
    run(mk(8'h05, 0, 0, 0), 1, 0, d);
    run(mk(K_PGEE, 1, 3'h0, 0), 1, 0, d);
    run(mk(K_PGEE, 1, 3'h5, 0), 1, 0, d);
    axi_wr(A_PROT, 32'h7, r);
    run(mk(K_ERALL, 0, 0, 0), 1, 0, d);
    run(mk(K_ERBLK, 1, 0, 0), 1, 0, d);
    axi_wr(A_PROT, 32'hb, r);
    run(mk(K_ERBLK, 0, 0, 0), 1, 0, d);
    run(mk(K_FMARG, 0, 0, 16'h0001), 1, 0, d);
    run(mk(K_OVR, 0, 0, 16'h0001), 1, 0, d);
    // A launch made while the access error stands must not run
    s0 = n_start;
    launch(mk(8'h05, 0, 0, 0));
    launch(mk(K_EVBLK, 1, 0, 0));
    repeat (SETUP_CYC + 4) @(posedge i_clk);
    axi_rd(A_STAT, d, r);
    check("err_hold", d[7:0], 8'ha0);
    check("no_start", n_start - s0, 0);
    axi_wr(A_STAT, 32'h20, r);
  endtask : t_refuse

  task automatic t_cmds();
    logic [31:0] d;
    logic [1:0] r;
    efail <= 1'b1;
    run(mk(K_EVALL, 0, 0, 0), 0, 1, d);
    check("vfail", d[S_FAIL], 1'b1);
    efail <= 1'b0;
    run(mk(K_EVBLK, 1, 0, 0), 0, 1, d);
    check("vpass", {d[S_FAIL], last_arr.ee}, 2'b01);
    run(mk(K_EVEE, 1, 3'h3, 16'h0040), 0, 1, d);
    check("sect", {last_arr.cnt, last_arr.addr}, {3'h3, 16'h0040});
    run(mk(K_PGEE, 1, 3'h1, 0), 0, 1, d);
    run(mk(K_PGEE, 1, 3'h4, 0), 0, 1, d);
    check("pg_cnt", last_arr.cnt, 3'h4);
    run(mk(K_EREE, 1, 0, 16'h0100), 0, 1, d);
    axi_wr(A_PROT, 32'h8, r);
    run(mk(K_ERBLK, 1, 0, 0), 0, 1, d);
    axi_wr(A_PROT, 32'hf, r);
    run(mk(K_ERALL, 0, 0, 0), 0, 1, d);
    run(mk(K_UNSEC, 0, 0, 0), 0, 2, d);
    check("unsec_ver", o_arr.verify, 1'b1);
  endtask : t_cmds

  task automatic t_margin();
    eccs_rd_rsp_t s;
    logic [31:0] d;
    logic [1:0] r;
    run(mk(K_UMARG, 0, 0, 16'h0001), 0, 0, d);
    axi_rd(A_MARG, d, r);
    check("marg_u", d, 32'h1);
    rdq(1'b0, 1'b0, s);
    check("marg_rd", s.margin, 1'b1);
    conc(mk(K_PGEE, 1, 3'h1, 0), 1'b1, 1'b0, 1'b1);
    special <= 1'b1;
    repeat (4) @(posedge i_clk);
    run(mk(K_FMARG, 0, 0, 16'h0002), 0, 0, d);
    axi_rd(A_MARG, d, r);
    check("marg_f", d, 32'h6);
    run(mk(K_UMARG, 0, 0, 16'h0000), 0, 0, d);
    rdq(1'b1, 1'b0, s);
    check("marg_off", s.margin, 1'b0);
    special <= 1'b0;
  endtask : t_margin

  task automatic t_override();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(A_KEY, OVR_KEY, r);
    run(mk(K_OVR, 0, 0, 16'h0002), 0, 0, d);
    axi_rd(A_PROT, d, r);
    check("ovr_on", d[5:0], 6'h2f);
    axi_rd(A_KEY, d, r);
    check("key_rd", d, 32'h0);
    run(mk(K_OVR, 0, 0, 16'h0000), 0, 0, d);
    axi_rd(A_PROT, d, r);
    check("ovr_off", d[5:4], 2'h0);
  endtask : t_override

  // Both requests held: never two grants at once, turns are shared
  task automatic t_arb();
    int np;
    int ne;
    int nb;
    np = 0;
    ne = 0;
    nb = 0;
    @(posedge i_clk);
    rd.pf_req <= 1'b1;
    rd.ee_req <= 1'b1;
    rd.hb <= 1'b0;
    repeat (8) begin
      @(negedge i_clk);
      np += (o_rd.pf_gnt === 1'b1);
      ne += (o_rd.ee_gnt === 1'b1);
      nb += (o_rd.pf_gnt === 1'b1 && o_rd.ee_gnt === 1'b1);
    end
    check("one_read", nb, 0);
    check("shared", np >= 2 && ne >= 2, 1'b1);
    @(posedge i_clk);
    rd.pf_req <= 1'b0;
    rd.ee_req <= 1'b0;
  endtask : t_arb

  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_refuse();
    t_cmds();
    t_margin();
    t_override();
    conc(mk(K_PGEE, 1, 3'h2, 0), 1'b1, 1'b0, 1'b0);
    conc(mk(K_PGEE, 1, 3'h2, 0), 1'b0, 1'b0, 1'b1);
    conc(mk(K_PGEE, 1, 3'h2, 0), 1'b0, 1'b1, 1'b0);
    conc(mk(K_EREE, 1, 0, 0), 1'b1, 1'b0, 1'b0);
    conc(mk(K_ERBLK, 1, 0, 0), 1'b1, 1'b0, 1'b1);
    conc(mk(K_ERALL, 0, 0, 0), 1'b1, 1'b0, 1'b1);
    conc(mk(K_PGPF, 0, 0, 0), 1'b1, 1'b0, 1'b1);
    conc(mk(K_PGPF, 0, 0, 0), 1'b1, 1'b1, 1'b0);
    t_arb();
    results();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
endmodule : tb_top
`default_nettype wire
